// ===== adc_ctrl_pkg.sv
// Notes on behaviour
// [R1] Two-bit burnout select picks off or three currents
// [R2] Temperature diode selection forces burnout off, bias on
// [R3] Offset cancel off: plain single conversions
// [R4] Offset cancel: normal minus swapped, halved
// [R5] Offset cancel doubles time per result
// [R6] Continuous with cancel: back-to-back one-shots, filter reset
// [R7] Gain codes 0-5: analog gain, digital gain one
// [R8] Gain codes 6-7: analog 16, digital 2 or 4
// [R9] Digital gain is shift left with rounding
// [R10] Settings latch at conversion start only
package adc_ctrl_pkg;

    // ****************************************************************
    // Field codes
    // ****************************************************************
    localparam logic [1:0] BURN_OFF      = 2'h0;   // No source/sink current
    localparam logic [1:0] BURN_0U9      = 2'h1;   // 0.9 uA
    localparam logic [1:0] BURN_3U7      = 2'h2;   // 3.7 uA
    localparam logic [1:0] BURN_15U      = 2'h3;   // 15 uA
    localparam logic [7:0] SEL_TEMP      = 8'hDE;  // Temperature diode pair
    localparam logic [1:0] MODE_CONT     = 2'h3;   // Continuous conversion
    localparam logic [2:0] GAIN_X32      = 3'h6;   // First digital-gain code
    localparam logic [2:0] GAIN_X64      = 3'h7;   // Second digital-gain code
    localparam logic [2:0] AGAIN_X16     = 3'h5;   // Analog gain index of 16x
    localparam logic [2:0] AGAIN_RESET   = 3'h1;   // Analog gain index after reset (1x)
    localparam logic [1:0] DSHIFT_NONE   = 2'h0;   // Digital gain 1
    localparam logic [1:0] DSHIFT_X2     = 2'h1;   // Digital gain 2
    localparam logic [1:0] DSHIFT_X4     = 2'h2;   // Digital gain 4
    localparam int         DATA_W        = 16;     // Result width
    localparam int         ACC_W         = 20;     // Raw filter word width

endpackage

// ===== adc_input_gain_autozero_ctrl.sv
`timescale 1ns/100ps
module adc_input_gain_autozero_ctrl (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    // Host settings
    input  wire logic [1:0]                burnoutSelect,
    input  wire logic [7:0]                inputSelectCode,
    input  wire logic                      scanActive,
    input  wire logic [7:0]                scanEntryCode,
    input  wire logic                      inputSwapOffsetCancel,
    input  wire logic [1:0]                conversionModeSelect,
    input  wire logic [2:0]                gainCode,
    // Conversion control
    input  wire logic                      convStart,
    input  wire logic                      filterDone,
    input  wire logic signed [19:0]        filterWord,
    // Analog controls
    output logic      [1:0]                burnoutCurrent_reg,
    output logic                           diodeBias_reg,
    output logic                           inputSwap_reg,
    output logic      [2:0]                analogGain_reg,
    output logic      [1:0]                digitalShift_reg,
    output logic                           filterReset_reg,
    output logic                           converting_reg,
    // Result
    output logic signed [15:0]             result_reg,
    output logic                           resultValid_reg
);

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    typedef enum logic [1:0] {IDLE, CONV_NORM, CONV_SWAP} seq_e;

    seq_e                      state_reg;      // Conversion phase
    seq_e                      state_next;
    logic                      azLatched_reg;  // Offset cancel latched at start
    logic                      contLatched_reg; // Continuous with cancel latched at start
    logic signed [15:0]        normRes_reg;    // Result of normal phase
    logic signed [15:0]        gained;         // Current phase, gain applied
    logic                      tempSel;        // Diode pair is selected
    logic                      startOk;        // Begin a new result
    logic                      restart;        // Continuous: chain next result
    logic signed [16:0]        azDiff;         // Normal minus swapped
    logic [2:0]                aGainNext;
    logic [1:0]                dShiftNext;

    // ****************************************************************
    // Decodes
    // ****************************************************************
    // [R2] temperature diode detect
    assign tempSel = scanActive ? (scanEntryCode == adc_ctrl_pkg::SEL_TEMP)
                                : (inputSelectCode == adc_ctrl_pkg::SEL_TEMP);
    // [R7] analog gain follows code up to 16x
    assign aGainNext = (gainCode >= adc_ctrl_pkg::GAIN_X32) ? adc_ctrl_pkg::AGAIN_X16
                                                            : gainCode;
    // [R8] digital gain for top two codes
    assign dShiftNext = (gainCode == adc_ctrl_pkg::GAIN_X64) ? adc_ctrl_pkg::DSHIFT_X4 :
                        (gainCode == adc_ctrl_pkg::GAIN_X32) ? adc_ctrl_pkg::DSHIFT_X2 :
                                                               adc_ctrl_pkg::DSHIFT_NONE;
    // [R6] continuous with cancel chains the next result itself
    assign restart = contLatched_reg;
    assign startOk = (state_reg == IDLE) && (convStart || restart);
    // [R4] halve the difference
    assign azDiff  = (17'(normRes_reg) - 17'(gained)) >>> 1;

    gain_shift_round u_gain (
        .rawWord    (filterWord),
        .shiftAmt   (digitalShift_reg),
        .resultWord (gained)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE: begin
                // Host request or chained restart, no gap beyond one idle cycle
                if (startOk) begin
                    state_next = CONV_NORM;
                end
            end
            CONV_NORM: begin
                // [R5] second period when cancelling
                if (filterDone) begin
                    state_next = azLatched_reg ? CONV_SWAP : IDLE;
                end
            end
            CONV_SWAP: begin
                if (filterDone) begin
                    state_next = IDLE;
                end
            end
            // Unused code: fall back to idle
            default: begin
                state_next = IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer and latched settings
    // ****************************************************************
    // Settings latch only at start, so mid-conversion writes wait
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg        <= IDLE;
            azLatched_reg    <= 1'b0;
            contLatched_reg  <= 1'b0;
            analogGain_reg   <= adc_ctrl_pkg::AGAIN_RESET;
            digitalShift_reg <= adc_ctrl_pkg::DSHIFT_NONE;
            converting_reg   <= 1'b0;
        end else begin
            state_reg      <= state_next;
            converting_reg <= (state_next != IDLE);
            // [R10] latch at conversion start
            if (startOk) begin
                azLatched_reg    <= inputSwapOffsetCancel;
                contLatched_reg  <= inputSwapOffsetCancel &&
                                    (conversionModeSelect == adc_ctrl_pkg::MODE_CONT);
                analogGain_reg   <= aGainNext;
                digitalShift_reg <= dShiftNext;
            end
        end
    end

    // ****************************************************************
    // Analog side controls
    // ****************************************************************
    // Burnout may follow the host at any time; it is a separate source
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            burnoutCurrent_reg <= adc_ctrl_pkg::BURN_OFF;
            diodeBias_reg      <= 1'b0;
        end else begin
            // [R1] [R2] burnout decode with diode override
            burnoutCurrent_reg <= tempSel ? adc_ctrl_pkg::BURN_OFF : burnoutSelect;
            diodeBias_reg      <= tempSel;
        end
    end

    // Swap inputs only during the second phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            inputSwap_reg   <= 1'b0;
            filterReset_reg <= 1'b0;
        end else begin
            // [R3] [R4] swap only in second phase
            inputSwap_reg   <= (state_next == CONV_SWAP);
            // [R6] filter reset after each phase, only when offset cancel is latched
            filterReset_reg <= filterDone && (state_reg != IDLE) && azLatched_reg;
        end
    end

    // ****************************************************************
    // Results
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            normRes_reg     <= '0;
            result_reg      <= '0;
            resultValid_reg <= 1'b0;
        end else begin
            resultValid_reg <= 1'b0;
            if (filterDone && state_reg == CONV_NORM) begin
                if (azLatched_reg) begin
                    normRes_reg <= gained;
                end else begin
                    // [R3] plain result
                    result_reg      <= gained;
                    resultValid_reg <= 1'b1;
                end
            end else if (filterDone && state_reg == CONV_SWAP) begin
                // [R4] cancelled result
                result_reg      <= azDiff[15:0];
                resultValid_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_diode_burnout: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
        tempSel |=> (burnoutCurrent_reg == adc_ctrl_pkg::BURN_OFF) && diodeBias_reg)
        else $error("Burnout not forced off on diode select");
    chk_burn_decode: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
        !tempSel |=> burnoutCurrent_reg == $past(burnoutSelect))
        else $error("Burnout select not followed");
    chk_no_swap_plain: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        (!azLatched_reg && state_reg != IDLE) |-> !inputSwap_reg)
        else $error("Swap seen without offset cancel");
    chk_plain_result: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        (filterDone && state_reg == CONV_NORM && !azLatched_reg) |=> resultValid_reg)
        else $error("Plain conversion gave no result");
    sequence normDone;
        filterDone && state_reg == CONV_NORM && azLatched_reg;
    endsequence
    chk_two_phases: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
        normDone |=> state_reg == CONV_SWAP && !resultValid_reg)
        else $error("Offset cancel skipped second phase");
    chk_az_result: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4]
        (filterDone && state_reg == CONV_SWAP) |=> resultValid_reg &&
            17'(result_reg) == $past(azDiff))
        else $error("Cancelled result wrong");
    chk_filter_reset: assert property (@(posedge sys_clk) disable iff (!resetn) // [R6]
        normDone |=> filterReset_reg)
        else $error("Filter not reset between phases");
    chk_gain_split: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
        (startOk && gainCode == adc_ctrl_pkg::GAIN_X64) |=>
            analogGain_reg == adc_ctrl_pkg::AGAIN_X16 &&
            digitalShift_reg == adc_ctrl_pkg::DSHIFT_X4)
        else $error("Gain split wrong for top code");
    chk_gain_low: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
        (startOk && gainCode < adc_ctrl_pkg::GAIN_X32) |=>
            analogGain_reg == $past(gainCode) &&
            digitalShift_reg == adc_ctrl_pkg::DSHIFT_NONE)
        else $error("Gain split wrong for analog code");
    chk_hold_mid: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
        (state_reg != IDLE && !startOk) |=> $stable(analogGain_reg))
        else $error("Gain changed mid conversion");

    chk_cont_chain: assert property (@(posedge sys_clk) disable iff (!resetn) // [R6]
        (filterDone && state_reg == CONV_SWAP && contLatched_reg) |=>
            ##1 state_reg == CONV_NORM)
        else $error("Continuous cancel did not chain");
endmodule // adc_input_gain_autozero_ctrl

// ===== filter_model.sv
`timescale 1ns/100ps
// Behavioural decimation filter: one word per phase after a set delay
module filter_model (
    // Clock, reset and sequencer state
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic               converting_reg,
    input  wire logic               inputSwap_reg,
    // Words to return and the timer count at which each phase ends
    input  wire logic signed [19:0] normWord,
    input  wire logic signed [19:0] swapWord,
    input  wire logic [3:0]         dly,
    // Filter outputs
    output logic                    filterDone,
    output logic signed [19:0]      filterWord
);
    // ****************************************************************
    // Phase timer
    // ****************************************************************
    logic [3:0] cnt;   // Cycles into the current phase

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt        <= 4'h0;
            filterDone <= 1'b0;
            filterWord <= 20'h0;
        end else begin
            filterDone <= 1'b0;
            // Word is stale outside the strobe, so scramble it on every cycle without the strobe
            filterWord <= ~filterWord;
            if (!converting_reg || filterDone) begin
                cnt <= 4'h0;
            end else if (cnt == dly) begin
                cnt        <= 4'h0;
                filterDone <= 1'b1;
                filterWord <= inputSwap_reg ? swapWord : normWord;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // filter_model

// ===== gain_shift_round.sv
`timescale 1ns/100ps
// Digital gain: shift raw filter word left, round to result, saturate
module gain_shift_round (
    // Raw signed filter word and shift
    input  wire logic signed [adc_ctrl_pkg::ACC_W-1:0]  rawWord,
    input  wire logic        [1:0]                      shiftAmt,
    // Rounded, saturated result
    output logic      signed [adc_ctrl_pkg::DATA_W-1:0] resultWord
);
    localparam int DROP = adc_ctrl_pkg::ACC_W - adc_ctrl_pkg::DATA_W;
    localparam int EXT  = adc_ctrl_pkg::ACC_W + 4;

    logic signed [EXT-1:0] shifted;   // Gain applied with headroom
    logic signed [EXT-1:0] rounded;   // Half LSB added before truncation
    logic signed [EXT-DROP-1:0] trunc; // Candidate result, still wide
    logic signed [EXT-DROP-1:0] maxV;
    logic signed [EXT-DROP-1:0] minV;

    // [R9] shift and round
    assign shifted = EXT'(rawWord) <<< shiftAmt;
    assign rounded = shifted + (EXT'(1) <<< (DROP - 1));
    assign trunc   = rounded[EXT-1:DROP];
    assign maxV    = (EXT-DROP)'((1 <<< (adc_ctrl_pkg::DATA_W - 1)) - 1);
    assign minV    = -maxV - (EXT-DROP)'(1);

    // Saturate so large gain never wraps sign
    always_comb begin
        if (trunc > maxV) begin
            resultWord = maxV[adc_ctrl_pkg::DATA_W-1:0];
        end else if (trunc < minV) begin
            resultWord = minV[adc_ctrl_pkg::DATA_W-1:0];
        end else begin
            resultWord = trunc[adc_ctrl_pkg::DATA_W-1:0];
        end
    end
endmodule // gain_shift_round

// ===== tb_adc_input_gain_autozero_ctrl.sv
`timescale 1ns/100ps
module tb_adc_input_gain_autozero_ctrl;
    // ****************************************************************
    // Signals, notes and counters
    // ****************************************************************
    logic               sys_clk, resetn, scanActive, inputSwapOffsetCancel, convStart;
    logic [1:0]         burnoutSelect, conversionModeSelect, burnoutCurrent_reg, digitalShift_reg;
    logic [7:0]         inputSelectCode, scanEntryCode;
    logic [2:0]         gainCode, analogGain_reg;
    logic [3:0]         dly;
    logic signed [19:0] filterWord, normWord, swapWord;
    logic signed [15:0] result_reg;
    logic               filterDone, diodeBias_reg, inputSwap_reg, filterReset_reg;
    logic               converting_reg, resultValid_reg;
    int                 failures = 0, checks = 0, nDone = 0, nRst = 0;
    logic [31:0]        seed = 32'h6D61;
    logic signed [15:0] expRes[$];   // Expected results, oldest first
    int                 expDone[$];  // Expected filter phases per result
    int                 expRst[$];   // Expected filter resets per result

    adc_input_gain_autozero_ctrl dut_u (.sys_clk, .resetn, .burnoutSelect, .inputSelectCode,
        .scanActive, .scanEntryCode, .inputSwapOffsetCancel, .conversionModeSelect, .gainCode,
        .convStart, .filterDone, .filterWord, .burnoutCurrent_reg, .diodeBias_reg,
        .inputSwap_reg, .analogGain_reg, .digitalShift_reg, .filterReset_reg, .converting_reg,
        .result_reg, .resultValid_reg);
    filter_model fm_u (.sys_clk, .resetn, .converting_reg, .inputSwap_reg, .normWord,
        .swapWord, .dly, .filterDone, .filterWord);

    always #25 sys_clk = ~sys_clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Shift, add half of the dropped LSBs, saturate to 16 bits
    function automatic logic signed [15:0] rnd(input logic signed [19:0] w, input logic [1:0] sh);
        logic signed [23:0] v;
        v = w;
        v = (v <<< sh) + 24'sh000008;
        v = v >>> 4;
        if (v > 24'sh007FFF) return 16'sh7FFF;
        if (v < 24'shFF8000) return 16'sh8000;
        return v[15:0];
    endfunction

    function automatic logic signed [15:0] calc(input logic signed [19:0] n, s,
                                                input logic [2:0] g, input logic c);
        logic [1:0]         sh;
        logic signed [16:0] d;
        sh = (g > 3'h5) ? 2'(g - 3'h5) : 2'h0;
        d  = rnd(n, sh);
        if (c) d = (d - rnd(s, sh)) >>> 1;
        return d[15:0];
    endfunction

    task automatic check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        failures += expRes.size();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One result, or two back-to-back: start held, or one start chained by the device
    task automatic conv(input logic [2:0] g, input logic c, input logic signed [19:0] n, s,
                        input logic b2b);
        int   k;
        logic chain;
        @(posedge sys_clk);
        chain = b2b && (conversionModeSelect == adc_ctrl_pkg::MODE_CONT);
        gainCode <= g;
        inputSwapOffsetCancel <= c;
        normWord <= n;
        swapWord <= s;
        convStart <= 1'b1;
        repeat (b2b ? 2 : 1) begin
            expRes.push_back(calc(n, s, g, c));
            expDone.push_back(c ? 2 : 1);
            expRst.push_back(c ? 2 : 0);
        end
        @(posedge sys_clk);
        if (!b2b || chain) convStart <= 1'b0;
        if (!b2b) begin
            gainCode <= ~g;
            inputSwapOffsetCancel <= ~c;
        end
        @(posedge sys_clk);
        #1 check(analogGain_reg, (g > 3'h5) ? 3'h5 : g);
        check(digitalShift_reg, (g > 3'h5) ? g - 3'h5 : 3'h0);
        // Chain flag is taken at each start, so clearing the mode now stops after the next
        if (chain) conversionModeSelect <= 2'h0;
        repeat (b2b ? 2 : 1) begin
            k = 0;
            while (k < 400) begin
                @(posedge sys_clk);
                k++;
                if (resultValid_reg) break;
            end
            convStart <= 1'b0;
        end
    endtask

    // Monitor: count phases and resets, compare each result with the oldest note
    always @(posedge sys_clk) begin
        if (filterDone) nDone++;
        if (filterReset_reg) nRst++;
        if (resultValid_reg) begin
            if (expRes.size() == 0) check(expRes.size(), 32'h1);
            else begin
                check(result_reg, expRes.pop_front());
                check(nDone, expDone.pop_front());
                check(nRst, expRst.pop_front());
            end
            nDone = 0;
            nRst = 0;
        end
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        end_sim;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {sys_clk, resetn, convStart, scanActive, inputSwapOffsetCancel} = 5'h0;
        {burnoutSelect, conversionModeSelect, inputSelectCode, scanEntryCode} = 20'h0;
        {gainCode, normWord, swapWord} = 43'h0;
        dly = 4'h3;
        repeat (2) @(posedge sys_clk);
        #1 check(analogGain_reg, adc_ctrl_pkg::AGAIN_RESET);
        check({result_reg, resultValid_reg, converting_reg, burnoutCurrent_reg,
               digitalShift_reg, diodeBias_reg, inputSwap_reg, filterReset_reg}, 32'h0);
        @(posedge sys_clk) resetn <= 1'b1;
        // Select codes: direct and scan, diode and not, every current
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            seed = lfsr(seed);
            burnoutSelect <= i[1:0];
            scanActive <= i[3];
            inputSelectCode <= (i[2] == i[3]) ? 8'hDE : {1'b0, seed[6:0]};
            scanEntryCode <= i[2] ? {1'b0, seed[14:8]} : 8'hDE;
            repeat (2) @(posedge sys_clk);
            #1 check(burnoutCurrent_reg, i[2] ? i[1:0] : 2'h0);
            check(diodeBias_reg, !i[2]);
        end
        $display("test burnout done");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            dly <= {seed[17:16], 2'h3};
            // Continuous with cancel would chain; that case has its own test below
            conversionModeSelect <= i[3] ? {1'b0, seed[20]} : seed[21:20];
            conv(i[2:0], i[3], {seed[31:22], seed[9:0]}, {seed[9:0], seed[31:22]}, 1'b0);
        end
        conv(3'h7, 1'b1, 20'sh7FFFF, 20'sh80000, 1'b0);
        conv(3'h5, 1'b0, 20'sh7FFF8, 20'sh0, 1'b0);
        $display("test gain done");
        conversionModeSelect <= 2'h0;
        conv(3'h2, 1'b1, 20'sh01234, 20'shFEDCB, 1'b1);
        conversionModeSelect <= adc_ctrl_pkg::MODE_CONT;
        conv(3'h6, 1'b1, 20'sh05678, 20'shFA987, 1'b1);
        $display("test continuous done");
        // Let the monitor take the last result before the verdict
        repeat (4) @(posedge sys_clk);
        end_sim;
    end
endmodule // tb_adc_input_gain_autozero_ctrl
